// >>> rtl/blt_cal_flags.sv
/*
  Calibration-done flags of one byte lane.
  Assumes one-cycle measurement-done pulses from the calibration engine.
*/
`timescale 1ns/100ps
module blt_cal_flags
  import blt_pkg::*;
#(
  parameter logic [NUM_CAL_LINES-1:0] LINE_PRESENT = '1
)
(
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rstn,
  // Measurement events and flags
  input  wire logic [NUM_CAL_LINES-1:0] meas_done,
  output logic      [NUM_CAL_LINES-1:0] cal_done_flags
);

  logic [NUM_CAL_LINES-1:0] flag_reg;
  logic [NUM_CAL_LINES-1:0] held;
  logic                     clear_all;

  // Flags clear together once every present line is done and held
  assign clear_all = &(flag_reg | ~LINE_PRESENT) & &(held | ~LINE_PRESENT);
  assign cal_done_flags = flag_reg;

  for (genvar i = 0; i < NUM_CAL_LINES; i++)
  begin : g_flag
    logic [1:0] age_reg;
    assign held[i] = (age_reg >= 2'(CAL_MIN_HOLD));

    always_ff @(posedge clock or negedge rstn)
    begin
      if (!rstn)
        flag_reg[i] <= 1'b0;
      else
        flag_reg[i] <= (flag_reg[i] & ~clear_all) | (meas_done[i] & LINE_PRESENT[i]);
    end

    always_ff @(posedge clock or negedge rstn)
    begin
      if (!rstn)
        age_reg <= 2'd0;
      else if (!flag_reg[i] || clear_all)
        age_reg <= 2'd0;
      else if (!held[i])
        age_reg <= age_reg + 2'd1;
    end
  end

endmodule // blt_cal_flags

// >>> rtl/blt_lev_pipe.sv
/*
  Write-leveling pipeline select of one byte lane: whole clock periods, up to three,
  contained in the leveling delay, from the measured period.
  Assumes the leveling delay is given in the same delay-line units.
*/
`timescale 1ns/100ps
module blt_lev_pipe
  import blt_pkg::*;
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rstn,
  // Period and delay
  input  wire logic [PERIOD_W-1:0] period,
  input  wire logic [PERIOD_W-1:0] lev_delay,
  // Pipeline select
  output logic      [1:0]          pipe_sel
);

  logic [PERIOD_W+1:0] p1;
  logic [PERIOD_W+1:0] p2;
  logic [PERIOD_W+1:0] p3;
  logic [PERIOD_W+1:0] d;

  assign p1 = {2'b00, period};
  assign p2 = {1'b0, period, 1'b0};
  assign p3 = p1 + p2;
  assign d  = {2'b00, lev_delay};

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      pipe_sel <= 2'd0;
    else if (period == '0)
      pipe_sel <= 2'd0;
    else if (d >= p3)
      pipe_sel <= 2'd3;
    else if (d >= p2)
      pipe_sel <= 2'd2;
    else if (d >= p1)
      pipe_sel <= 2'd1;
    else
      pipe_sel <= 2'd0;
  end

endmodule // blt_lev_pipe

// >>> rtl/blt_pkg.sv
/*
  Package for the byte lane training status block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 32-bit AXI4-Lite register bus and one configuration clock.
*/
package blt_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  LANE_STRIDE     = 8'h08;
  localparam logic [7:0]  STATUS0_OFFSET  = 8'h00;
  localparam logic [7:0]  STATUS2_OFFSET  = 8'h04;
  localparam logic [7:0]  IRQ_STAT_OFFSET = 8'h80;
  localparam logic [7:0]  IRQ_MASK_OFFSET = 8'h84;
  localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
  localparam logic [3:0]  IRQ_RESET       = 4'h0;

  // ****************************************************************
  // First status word fields
  // ****************************************************************
  localparam int SAMPLE_POS      = 28;
  localparam int GATE_FAIL_LSB   = 24;
  localparam int GATE_PERIOD_LSB = 16;
  localparam int PLL_LOCK_POS    = 15;
  localparam int LEV_PERIOD_LSB  = 7;
  localparam int LEV_FAIL_POS    = 6;
  localparam int LEV_DONE_POS    = 5;
  localparam int CAL_DONE_LSB    = 0;
  localparam int NUM_CAL_LINES   = 5;
  localparam int NUM_RANKS       = 4;
  localparam int PERIOD_W        = 8;

  // ****************************************************************
  // Second status word fields
  // ****************************************************************
  localparam int ERR_CODE_LSB    = 8;
  localparam int ERR_CODE_W      = 4;
  localparam int EYE_BITS        = 8;
  localparam logic [7:0] EYE_FAIL_MASK = 8'h55;

  // ****************************************************************
  // Interrupt events and timing
  // ****************************************************************
  localparam int IRQ_W          = 4;
  localparam int IRQ_LEV_FAIL   = 0;
  localparam int IRQ_GATE_FAIL  = 1;
  localparam int IRQ_EYE_FAIL   = 2;
  localparam int IRQ_LOCK_LOSS  = 3;
  localparam int CAL_MIN_HOLD   = 2;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

endpackage

// >>> rtl/blt_status.sv
/*
  Training status register bank of the data byte lanes, AXI4-Lite slave,
  with a masked interrupt on training failures and lock loss.
  Assumes engine event inputs are one-cycle pulses synchronous to clock.
*/
// The AXI4-Lite slave port and the register addresses were decided locally.
// Contract
// - Latch returned data at bit 28 during leveling
// - Bits 27-24 flag gate training fail per rank
// - Bits 23-16 hold gate line measured period
// - Bit 15 shows lane PLL lock
// - Bits 14-7 leveling period; drives leveling pipeline
// - Bit 6 flags write leveling failure
// - Bit 5 flags write leveling completed
// - Bit 4 leveling line calibration done
// - Bit 3 gate line calibration done
// - Bit 2 complementary strobe calibration done, if present
// - Bit 1 read strobe line calibration done
// - Bit 0 write data line calibration done
// - Done flags held two cycles, clear when all done
// - Separate status words per lane, 0 to 8
// - Status read-only, zero after reset
// - Second word: eye and deskew warnings, errors
// - Bits 11-8 error code when errors present
`timescale 1ns/100ps
module blt_status
  import blt_pkg::*;
#(
  parameter int                     NUM_LANES    = 9,
  parameter logic [NUM_CAL_LINES-1:0] LINE_PRESENT = '1
)
(
  // Clock and reset
  input  wire logic                             clock,
  input  wire logic                             rstn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]                       s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]                       s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // Lane training control and leveling sample
  input  wire logic [NUM_LANES-1:0]             training_start,
  input  wire logic                             sw_leveling_active,
  input  wire logic [NUM_LANES-1:0]             leveling_dq_valid,
  input  wire logic [NUM_LANES-1:0]             leveling_dq,
  // Gate training, periods, lane lock and leveling results
  input  wire logic [NUM_LANES*NUM_RANKS-1:0]   gate_training_fail,
  input  wire logic [NUM_LANES-1:0]             gate_period_valid,
  input  wire logic [NUM_LANES*PERIOD_W-1:0]    gate_measured_period,
  input  wire logic [NUM_LANES-1:0]             lane_pll_locked,
  input  wire logic [NUM_LANES-1:0]             leveling_period_valid,
  input  wire logic [NUM_LANES*PERIOD_W-1:0]    leveling_measured_period,
  input  wire logic [NUM_LANES*PERIOD_W-1:0]    leveling_delay,
  input  wire logic [NUM_LANES-1:0]             leveling_fail,
  input  wire logic [NUM_LANES-1:0]             leveling_complete,
  // Delay line measurement done pulses
  input  wire logic [NUM_LANES*NUM_CAL_LINES-1:0] meas_done,
  // Eye centering and deskew results
  input  wire logic [NUM_LANES*EYE_BITS-1:0]    eye_result,
  input  wire logic [NUM_LANES*ERR_CODE_W-1:0]  training_error_code,
  // Leveling pipeline and interrupt
  output logic [NUM_LANES*2-1:0]                leveling_pipe_sel,
  output logic                                  irq
);

  if (NUM_LANES < 1 || NUM_LANES > 16)
  begin : g_bad_lanes
    $error("NUM_LANES must lie in 1..16");
  end

  // ****************************************************************
  // Per-lane status fields
  // ****************************************************************
  logic [31:0]          word0 [NUM_LANES];
  logic [31:0]          word2 [NUM_LANES];
  logic [NUM_LANES-1:0] ev_lev_fail;
  logic [NUM_LANES-1:0] ev_gate_fail;
  logic [NUM_LANES-1:0] ev_eye_fail;
  logic [NUM_LANES-1:0] ev_lock_loss;

  for (genvar n = 0; n < NUM_LANES; n++)
  begin : g_lane
    logic                     sample_reg;
    logic [NUM_RANKS-1:0]     gate_fail_reg;
    logic [PERIOD_W-1:0]      gate_period_reg;
    logic                     pll_lock_reg;
    logic [PERIOD_W-1:0]      lev_period_reg;
    logic                     lev_fail_reg;
    logic                     lev_done_reg;
    logic [EYE_BITS-1:0]      eye_reg;
    logic [ERR_CODE_W-1:0]    err_code_reg;
    logic [NUM_CAL_LINES-1:0] cal_flags;
    logic [NUM_RANKS-1:0]     gate_in;
    logic [EYE_BITS-1:0]      eye_in;

    assign gate_in = gate_training_fail[n*NUM_RANKS +: NUM_RANKS];
    assign eye_in  = eye_result[n*EYE_BITS +: EYE_BITS];

    always_ff @(posedge clock or negedge rstn)
    begin
      if (!rstn)
        sample_reg <= 1'b0;
      else if (sw_leveling_active && leveling_dq_valid[n])
        sample_reg <= leveling_dq[n];
    end

    // Error bits: a fail in the start cycle wins over the clear
    always_ff @(posedge clock or negedge rstn)
    begin
      if (!rstn)
      begin
        gate_fail_reg <= '0;
        lev_fail_reg  <= 1'b0;
        lev_done_reg  <= 1'b0;
        eye_reg       <= '0;
      end
      else
      begin
        gate_fail_reg <= (gate_fail_reg & {NUM_RANKS{~training_start[n]}}) | gate_in;
        lev_fail_reg  <= (lev_fail_reg & ~training_start[n]) | leveling_fail[n];
        lev_done_reg  <= (lev_done_reg & ~training_start[n]) | leveling_complete[n];
        eye_reg       <= (eye_reg & {EYE_BITS{~training_start[n]}}) | eye_in;
      end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
      if (!rstn)
        err_code_reg <= '0;
      else if (|(eye_in & EYE_FAIL_MASK))
        err_code_reg <= training_error_code[n*ERR_CODE_W +: ERR_CODE_W];
      else if (training_start[n])
        err_code_reg <= '0;
    end

    // Periods change only on a measurement strobe
    always_ff @(posedge clock or negedge rstn)
    begin
      if (!rstn)
      begin
        gate_period_reg <= '0;
        lev_period_reg  <= '0;
      end
      else
      begin
        if (gate_period_valid[n])
          gate_period_reg <= gate_measured_period[n*PERIOD_W +: PERIOD_W];
        if (leveling_period_valid[n])
          lev_period_reg <= leveling_measured_period[n*PERIOD_W +: PERIOD_W];
      end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
      if (!rstn)
        pll_lock_reg <= 1'b0;
      else
        pll_lock_reg <= lane_pll_locked[n];
    end

    blt_cal_flags #(
      .LINE_PRESENT   (LINE_PRESENT)
    ) u_cal_flags (
      .clock          (clock),
      .rstn           (rstn),
      .meas_done      (meas_done[n*NUM_CAL_LINES +: NUM_CAL_LINES]),
      .cal_done_flags (cal_flags)
    );

    blt_lev_pipe u_lev_pipe (
      .clock          (clock),
      .rstn           (rstn),
      .period         (lev_period_reg),
      .lev_delay      (leveling_delay[n*PERIOD_W +: PERIOD_W]),
      .pipe_sel       (leveling_pipe_sel[n*2 +: 2])
    );

    // Flag order is write data, read strobe, read strobe n, gate, leveling
    always_comb
    begin
      word0[n]                                        = STATUS_RESET;
      word0[n][SAMPLE_POS]                            = sample_reg;
      word0[n][GATE_FAIL_LSB +: NUM_RANKS]            = gate_fail_reg;
      word0[n][GATE_PERIOD_LSB +: PERIOD_W]           = gate_period_reg;
      word0[n][PLL_LOCK_POS]                          = pll_lock_reg;
      word0[n][LEV_PERIOD_LSB +: PERIOD_W]            = lev_period_reg;
      word0[n][LEV_FAIL_POS]                          = lev_fail_reg;
      word0[n][LEV_DONE_POS]                          = lev_done_reg;
      word0[n][CAL_DONE_LSB +: NUM_CAL_LINES]         = cal_flags;
      word2[n]                                        = STATUS_RESET;
      word2[n][ERR_CODE_LSB +: ERR_CODE_W]            = err_code_reg;
      word2[n][EYE_BITS-1:0]                          = eye_reg;
    end

    assign ev_lev_fail[n]  = leveling_fail[n];
    assign ev_gate_fail[n] = |gate_in;
    assign ev_eye_fail[n]  = |(eye_in & EYE_FAIL_MASK);
    assign ev_lock_loss[n] = pll_lock_reg & ~lane_pll_locked[n];
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_w1c;
  logic [IRQ_W-1:0] irq_stat_next;
  logic             wr_fire;
  logic [7:0]       aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic             aw_have_reg;
  logic             w_have_reg;

  assign irq_events[IRQ_LEV_FAIL]  = |ev_lev_fail;
  assign irq_events[IRQ_GATE_FAIL] = |ev_gate_fail;
  assign irq_events[IRQ_EYE_FAIL]  = |ev_eye_fail;
  assign irq_events[IRQ_LOCK_LOSS] = |ev_lock_loss;

  assign irq_w1c = (wr_fire && aw_addr_reg == IRQ_STAT_OFFSET && w_strb_reg[0])
                   ? w_data_reg[IRQ_W-1:0] : '0;
  assign irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_events;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      irq_stat_reg <= IRQ_RESET;
    else
      irq_stat_reg <= irq_stat_next;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      irq_mask_reg <= IRQ_RESET;
    else if (wr_fire && aw_addr_reg == IRQ_MASK_OFFSET && w_strb_reg[0])
      irq_mask_reg <= w_data_reg[IRQ_W-1:0];
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_next & irq_mask_reg);
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic addr_mapped(input logic [7:0] a);
    logic [7:0] lane;
    lane = a / LANE_STRIDE;
    addr_mapped = (a[1:0] == 2'b00) &&
                  ((lane < 8'(NUM_LANES)) || a == IRQ_STAT_OFFSET ||
                   a == IRQ_MASK_OFFSET);
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [7:0] lane;
    lane = a / LANE_STRIDE;
    read_word = STATUS_RESET;
    if (a == IRQ_STAT_OFFSET)
      read_word[IRQ_W-1:0] = irq_stat_reg;
    else if (a == IRQ_MASK_OFFSET)
      read_word[IRQ_W-1:0] = irq_mask_reg;
    else if (lane < 8'(NUM_LANES) && (a % LANE_STRIDE) == STATUS0_OFFSET)
      read_word = word0[lane[3:0]];
    else if (lane < 8'(NUM_LANES) && (a % LANE_STRIDE) == STATUS2_OFFSET)
      read_word = word2[lane[3:0]];
  endfunction

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

  // Status words ignore writes; only the interrupt registers take them
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      w_strb_reg    <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_mapped(aw_addr_reg) ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= read_word(s_axi_araddr);
        s_axi_rresp  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // blt_status

// >>> test/blt_status_sva.sv
/*
  Bus handshake checks of the lane training status bank.
  Assumes it is bound to blt_status and sees only its ports.
*/
`timescale 1ns/100ps
module blt_status_sva
  import blt_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ****************************************************************
  // Handshake and response checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  AST_AW_DROP: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed high after take");
  AST_W_DROP: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("wready stayed high after take");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response not held");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data not held");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_R_DECERR: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr inside {[8'h48:8'h7F]} |=> s_axi_rresp == RESP_DECERR)
    else $error("unmapped read not refused");
  AST_R_RSVD: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr < 8'h48 && s_axi_araddr[1:0] == 2'b00
    |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:29] == 3'b000
    && (!$past(s_axi_araddr[2]) || s_axi_rdata[31:12] == 20'h0_0000))
    else $error("reserved status bits not zero");
endmodule // blt_status_sva

bind blt_status blt_status_sva u_sva (.clock, .rstn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// >>> test/tb_top.sv
/*
  Directed bench of the lane training status bank over AXI4-Lite.
  Assumes the default nine lanes with all delay lines present.
*/
`timescale 1ns/100ps
module tb_top
  import blt_pkg::*;
;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, sw_leveling_active = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [8:0]  training_start = '0, leveling_dq_valid = '0, leveling_dq = '0;
  logic [8:0]  gate_period_valid = '0, lane_pll_locked = '0, leveling_period_valid = '0;
  logic [8:0]  leveling_fail = '0, leveling_complete = '0;
  logic [35:0] gate_training_fail = '0, training_error_code = '0;
  logic [71:0] gate_measured_period = '0, leveling_measured_period = '0;
  logic [71:0] leveling_delay = '0, eye_result = '0;
  logic [44:0] meas_done = '0;
  logic [17:0] leveling_pipe_sel;
  int          n_mismatch = 0, samples_checked = 0;

  blt_status uut (.clock, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .training_start, .sw_leveling_active,
    .leveling_dq_valid, .leveling_dq, .gate_training_fail, .gate_period_valid,
    .gate_measured_period, .lane_pll_locked, .leveling_period_valid,
    .leveling_measured_period, .leveling_delay, .leveling_fail, .leveling_complete,
    .meas_done, .eye_result, .training_error_code, .leveling_pipe_sel, .irq);

  initial forever #4 clock = ~clock;

  // ****************************************************************
  // Bus tasks and checks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdt(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [7:0] w0(int n);
    return STATUS0_OFFSET + 8'(n) * LANE_STRIDE;
  endfunction

  function automatic logic [7:0] w2(int n);
    return STATUS2_OFFSET + 8'(n) * LANE_STRIDE;
  endfunction

  task automatic end_sim();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    for (int n = 0; n < 9; n++)
    begin
      rdt(w0(n));
      check(rd, STATUS_RESET);
      rdt(w2(n));
      check(rd, STATUS_RESET);
    end
    rdt(IRQ_MASK_OFFSET);
    check(rd, 32'(IRQ_RESET));
    wr(w0(0), 32'hFFFF_FFFF);
    check(32'(rs), 32'(RESP_OKAY));
    rdt(w0(0));
    check(rd, 32'h0000_0000);
    wr(8'h70, 32'h0000_0001);
    check(32'(rs), 32'(RESP_DECERR));
    rdt(8'h60);
    check(32'(rs), 32'(RESP_DECERR));
    // Lane 3 training events in one cycle
    @(posedge clock);
    lane_pll_locked[3] <= 1'b1;
    sw_leveling_active <= 1'b1;
    leveling_dq[3] <= 1'b1;
    leveling_dq_valid[3] <= 1'b1;
    gate_period_valid[3] <= 1'b1;
    gate_measured_period[31:24] <= 8'hA5;
    leveling_period_valid[3] <= 1'b1;
    leveling_measured_period[31:24] <= 8'h3C;
    leveling_delay[31:24] <= 8'h82;
    gate_training_fail[14] <= 1'b1;
    leveling_fail[3] <= 1'b1;
    leveling_complete[3] <= 1'b1;
    @(posedge clock);
    {leveling_dq_valid, gate_period_valid, leveling_period_valid} <= '0;
    {gate_training_fail, leveling_fail, leveling_complete, leveling_dq} <= '0;
    sw_leveling_active <= 1'b0;
    repeat (3) @(posedge clock);
    rdt(w0(3));
    check(rd, 32'h14A5_9E60);
    rdt(w0(4));
    check(rd, 32'h0000_0000);
    check(32'(leveling_pipe_sel[7:6]), 32'h0000_0002);
    // Lane 1 delay line measurements, complementary line last
    for (int k = 0; k < 5; k++)
      if (k != 2)
      begin
        @(posedge clock);
        meas_done[5+k] <= 1'b1;
        @(posedge clock);
        meas_done[5+k] <= 1'b0;
      end
    repeat (4) @(posedge clock);
    rdt(w0(1));
    check(rd, 32'h0000_001B);
    @(posedge clock);
    meas_done[7] <= 1'b1;
    @(posedge clock);
    meas_done[7] <= 1'b0;
    rdt(w0(1));
    check(rd, 32'h0000_001F);
    repeat (4) @(posedge clock);
    rdt(w0(1));
    check(rd, 32'h0000_0000);
    // Lane 5 eye results: warnings only, then one failure
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clock);
      eye_result[47:40] <= k ? 8'h01 : 8'hAA;
      training_error_code[23:20] <= k ? 4'h9 : 4'h7;
      @(posedge clock);
      eye_result <= '0;
      repeat (2) @(posedge clock);
      rdt(w2(5));
      check(rd, k ? 32'h0000_09AB : 32'h0000_00AA);
    end
    @(posedge clock);
    training_start[5] <= 1'b1;
    @(posedge clock);
    training_start[5] <= 1'b0;
    rdt(w2(5));
    check(rd, 32'h0000_0000);
    // Interrupt masking, clearing and lock loss
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h0000_0000);
    rdt(IRQ_STAT_OFFSET);
    check(rd, 32'h0000_0007);
    wr(IRQ_MASK_OFFSET, 32'h0000_0001);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h0000_0001);
    wr(IRQ_STAT_OFFSET, 32'h0000_0001);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h0000_0000);
    rdt(IRQ_STAT_OFFSET);
    check(rd, 32'h0000_0006);
    lane_pll_locked[3] <= 1'b0;
    wr(IRQ_MASK_OFFSET, 32'h0000_0008);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h0000_0001);
    rdt(w0(3));
    check(rd, 32'h14A5_1E60);
    wr(IRQ_STAT_OFFSET, 32'h0000_000F);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h0000_0000);
    end_sim();
  end
endmodule // tb_top
